// file: design/dac_control.v
// Contract
// RULE1 - 8, 16 and 32 bit accesses accepted; byte lanes of wider registers writable alone
// RULE2 - reserved bits read zero; software writes them zero
// RULE3 - run-in-standby keeps output buffer on in standby; not synchronised
// RULE4 - enable reads back at once, busy set; takes effect after delay
// RULE5 - soft reset one restores all registers and disables converter; zero ignored
// RULE6 - a write setting soft reset discards all other written bits
// RULE7 - soft reset done after delay; reset bit and busy clear together
// RULE8 - reference select codes internal 1V, analog supply, external; 3 reserved
// RULE9 - bypass bit lets buffer writes pass while protection is on
// RULE10 - pump disable zero leaves pump automatic, one forces it off
// RULE11 - left align selects placement of 10-bit value in value and buffer
// RULE12 - internal output enable routes output to analog comparator
// RULE13 - external output enable drives the output pin buffer
// RULE14 - empty event emitted when buffer empties if enabled
// RULE15 - enabled start event moves buffer to value and starts conversion
// RULE16 - enable set and clear registers share one enable state
// RULE17 - ones written to enable clear disable the matching interrupts
// RULE18 - protected registers reject writes while protection is on
// RULE19 - control_a is write protected and write synchronised
// RULE20 - empty flag sets on buffer move, clears on one or buffer write
// RULE21 - underrun flag sets on start event with empty buffer
// RULE22 - sync ready sets when busy falls, except after enable or reset
// RULE23 - value in bits 9:0 right aligned, bits 15:6 left aligned
// RULE24 - irq high while any flag and its enable are both set
`timescale 1ns/1ns
`include "dac_ctrl_map.vh"

module dac_control #(
   parameter AW          = 12,
   parameter SYNC_CYCLES = `SYNC_CYCLES
) (
   input  wire          pclk,            // bus clock
   input  wire          presetn,         // async reset, active low
   input  wire          psel,            // apb select
   input  wire          penable,         // apb access phase
   input  wire          pwrite,          // apb direction
   input  wire [AW-1:0] paddr,           // apb byte address
   input  wire [31:0]   pwdata,          // apb write data
   input  wire [3:0]    pstrb,           // apb byte strobes
   output wire [31:0]   prdata,          // apb read data
   output wire          pready,          // apb ready
   output wire          pslverr,         // apb error
   input  wire          write_protect,   // access controller protection on
   input  wire          standby,         // system in standby sleep
   input  wire          start_event,     // start conversion event pulse
   output wire          dac_on,          // converter enabled
   output wire [9:0]    dac_code,        // code being converted
   output wire          conv_start,      // pulse: new conversion
   output wire [1:0]    reference_select, // reference choice
   output wire          pump_off,        // voltage pump forced off
   output wire          internal_out,    // output to analog comparator
   output wire          external_out,    // output pin buffer on
   output wire          empty_event,     // pulse: buffer empty event
   output wire          irq              // interrupt request
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg        run_stdby_ff;
   reg        enable_ff;
   reg        soft_reset_ff;
   reg [7:0]  ctrl_b_ff;
   reg [1:0]  event_control_ff;
   reg [2:0]  ien_ff;
   reg [2:0]  flags_ff;
   reg [15:0] data_ff;
   reg [15:0] buf_ff;
   reg        buf_full_ff;
   reg        conv_on_ff;
   reg [9:0]  code_ff;
   reg        conv_start_ff;
   reg        empty_ev_ff;
   reg        data_cause_ff;
   reg        code_cause_ff;
   reg [31:0] rdata_ff;
   reg [2:0]  nxt_flags;

   wire       sync_busy;
   wire       sync_done;
   wire       left;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // upper address bits must be zero, else unmapped
   wire [3:0] idx     = paddr[5:2];
   wire       hi_zero = (paddr[AW-1:6] == {(AW-6){1'b0}});
   wire       setup   = psel & ~penable;
   wire       acc     = psel & penable;

   wire sel_a   = hi_zero & (idx == `IDX_CONTROL_A);
   wire sel_b   = hi_zero & (idx == `IDX_CONTROL_B);
   wire sel_ev  = hi_zero & (idx == `IDX_EVENT_CONTROL);
   wire sel_iec = hi_zero & (idx == `IDX_IRQ_ENABLE_CLEAR);
   wire sel_ies = hi_zero & (idx == `IDX_IRQ_ENABLE_SET);
   wire sel_fl  = hi_zero & (idx == `IDX_IRQ_FLAGS);
   wire sel_st  = hi_zero & (idx == `IDX_SYNC_STATUS);
   wire sel_dat = hi_zero & (idx == `IDX_CONV_VALUE);
   wire sel_buf = hi_zero & (idx == `IDX_CONV_BUFFER);
   wire mapped  = sel_a | sel_b | sel_ev | sel_iec | sel_ies | sel_fl |
                  sel_st | sel_dat | sel_buf;

   // buffer is the only register that the bypass bit can unlock
   wire prot_buf = write_protect & ~ctrl_b_ff[`BIT_BUF_PROT_BYPASS]; // RULE9
   wire prot_hit = pwrite & ((write_protect & mapped & ~sel_buf & ~sel_st) |
                             (prot_buf & sel_buf)); // RULE18 RULE19

   // a refused write answers at once instead of waiting on busy
   wire sync_reg = sel_a | sel_dat | sel_buf; // RULE19
   wire stall    = acc & pwrite & sync_reg & sync_busy & ~prot_hit;
   wire ro_write = pwrite & sel_st;
   wire err      = ~mapped | prot_hit | ro_write;

   assign pready  = ~stall;
   assign pslverr = acc & ~stall & err;

   // ----------------------------------------
   // write strobes
   // ----------------------------------------
   wire wr   = acc & pwrite & ~stall & ~err;
   wire lo   = pstrb[0]; // RULE1
   wire hi   = pstrb[1]; // RULE1
   wire [7:0] wb = pwdata[7:0];

   wire wr_a   = wr & sel_a & lo;
   // soft reset wins over every other bit of the same write
   wire wr_swr = wr_a & wb[`BIT_SOFT_RESET]; // RULE5
   wire wr_dat = wr & sel_dat & (lo | hi);
   wire wr_buf = wr & sel_buf & (lo | hi);

   // ----------------------------------------
   // write synchronisation
   // ----------------------------------------
   // control_a writes start the delay, as do value and buffer writes
   wire sync_start = wr_a | wr_dat | wr_buf; // RULE4 RULE19

   sync_delay #(
      .CYCLES (SYNC_CYCLES)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .start (sync_start),
      .busy  (sync_busy),
      .done  (sync_done)
   );

   // ----------------------------------------
   // start event and buffer transfer
   // ----------------------------------------
   assign left = ctrl_b_ff[`BIT_LEFT_ALIGN];

   // events are dropped while the converter is off
   wire ev_take  = start_event & conv_on_ff & event_control_ff[`BIT_START_EVENT_IN]; // RULE15
   wire ev_move  = ev_take & buf_full_ff;
   wire ev_under = ev_take & ~buf_full_ff; // RULE21
   wire sw_done  = sync_done & soft_reset_ff;

   wire [9:0] buf_code  = left ? buf_ff[15:6] : buf_ff[9:0];   // RULE11 RULE23
   wire [9:0] data_code = left ? data_ff[15:6] : data_ff[9:0]; // RULE11 RULE23

   // ----------------------------------------
   // flags
   // ----------------------------------------
   always @* begin
      nxt_flags = flags_ff;
      if (wr & sel_fl & lo) begin
         nxt_flags = flags_ff & ~wb[2:0];
      end
      if (wr_buf) begin
         nxt_flags[`BIT_IRQ_EMPTY] = 1'b0; // RULE20
      end
      // a set in the clearing cycle still wins
      if (ev_move) begin
         nxt_flags[`BIT_IRQ_EMPTY] = 1'b1; // RULE20
      end
      if (ev_under) begin
         nxt_flags[`BIT_IRQ_UNDERRUN] = 1'b1; // RULE21
      end
      if (sync_done & data_cause_ff & ~soft_reset_ff) begin
         nxt_flags[`BIT_IRQ_SYNC_READY] = 1'b1; // RULE22
      end
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_stdby_ff  <= 1'b0;
         enable_ff     <= 1'b0;
         soft_reset_ff <= 1'b0;
         ctrl_b_ff     <= `RST_BYTE;
         event_control_ff     <= 2'h0;
         ien_ff        <= 3'h0;
         flags_ff      <= 3'h0;
         data_ff       <= `RST_DATA;
         buf_ff        <= `RST_DATA;
         buf_full_ff   <= `RST_BUF_FULL;
         conv_on_ff    <= 1'b0;
         code_ff       <= 10'h000;
         conv_start_ff <= 1'b0;
         empty_ev_ff   <= 1'b0;
         data_cause_ff <= 1'b0;
         code_cause_ff <= 1'b0;
      end else if (sw_done) begin
         // reset done: every register back to its initial value
         run_stdby_ff  <= 1'b0; // RULE5
         enable_ff     <= 1'b0;
         soft_reset_ff <= 1'b0; // RULE7
         ctrl_b_ff     <= `RST_BYTE;
         event_control_ff     <= 2'h0;
         ien_ff        <= 3'h0;
         flags_ff      <= 3'h0;
         data_ff       <= `RST_DATA;
         buf_ff        <= `RST_DATA;
         buf_full_ff   <= `RST_BUF_FULL;
         conv_on_ff    <= 1'b0; // RULE5
         code_ff       <= 10'h000;
         conv_start_ff <= 1'b0;
         empty_ev_ff   <= 1'b0;
         data_cause_ff <= 1'b0;
         code_cause_ff <= 1'b0;
      end else begin
         conv_start_ff <= ev_move; // RULE15
         empty_ev_ff   <= ev_move & event_control_ff[`BIT_EMPTY_EVENT_OUT]; // RULE14
         flags_ff      <= nxt_flags;

         if (sync_start) begin
            data_cause_ff <= ~wr_a; // RULE22
            code_cause_ff <= wr_dat;
         end

         if (wr_swr) begin
            soft_reset_ff <= 1'b1; // RULE6
         end else if (wr_a) begin
            enable_ff    <= wb[`BIT_ENABLE]; // RULE4
            run_stdby_ff <= wb[`BIT_RUN_IN_STANDBY]; // RULE3
         end

         // enable change reaches the converter only at sync end
         if (sync_done & ~data_cause_ff) begin
            conv_on_ff <= enable_ff; // RULE4
         end

         if (wr & sel_b & lo) begin
            ctrl_b_ff <= wb & `MASK_CONTROL_B; // RULE2 RULE8
         end
         if (wr & sel_ev & lo) begin
            event_control_ff <= wb[1:0];
         end
         if (wr & sel_iec & lo) begin
            ien_ff <= ien_ff & ~wb[2:0]; // RULE16 RULE17
         end else if (wr & sel_ies & lo) begin
            ien_ff <= ien_ff | wb[2:0]; // RULE16
         end

         if (ev_move) begin
            data_ff <= buf_ff; // RULE15
            code_ff <= buf_code;
         end else begin
            if (wr_dat & lo) begin
               data_ff[7:0] <= wb; // RULE1
            end
            if (wr_dat & hi) begin
               data_ff[15:8] <= pwdata[15:8]; // RULE1
            end
            // only a value write moves the code at sync end
            if (sync_done & code_cause_ff) begin
               code_ff <= data_code;
            end
         end

         if (wr_buf & lo) begin
            buf_ff[7:0] <= wb;
         end
         if (wr_buf & hi) begin
            buf_ff[15:8] <= pwdata[15:8];
         end
         if (wr_buf) begin
            buf_full_ff <= 1'b1;
         end else if (ev_move) begin
            buf_full_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // read data, captured in the setup phase
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 32'h0000_0000;
      end else if (setup) begin
         rdata_ff <= 32'h0000_0000; // RULE2
         if (sel_a) begin
            rdata_ff[2:0] <= {run_stdby_ff, enable_ff, soft_reset_ff};
         end
         if (sel_b) begin
            rdata_ff[7:0] <= ctrl_b_ff;
         end
         if (sel_ev) begin
            rdata_ff[1:0] <= event_control_ff;
         end
         if (sel_iec | sel_ies) begin
            rdata_ff[2:0] <= ien_ff; // RULE16
         end
         if (sel_fl) begin
            rdata_ff[2:0] <= flags_ff;
         end
         if (sel_st) begin
            rdata_ff[`BIT_SYNC_BUSY] <= sync_busy;
         end
         if (sel_dat) begin
            rdata_ff[15:0] <= data_ff;
         end
         if (sel_buf) begin
            rdata_ff[15:0] <= buf_ff;
         end
      end
   end

   assign prdata = rdata_ff;

   // ----------------------------------------
   // converter side outputs
   // ----------------------------------------
   assign dac_on           = conv_on_ff;
   assign dac_code         = code_ff; // RULE23
   assign conv_start       = conv_start_ff;
   assign empty_event      = empty_ev_ff; // RULE14
   assign reference_select = ctrl_b_ff[`BIT_REF_SEL_HI:`BIT_REF_SEL_LO]; // RULE8
   assign pump_off         = ctrl_b_ff[`BIT_PUMP_DISABLE]; // RULE10
   assign internal_out     = conv_on_ff & ctrl_b_ff[`BIT_INT_OUT_EN]; // RULE12
   assign external_out     = conv_on_ff & ctrl_b_ff[`BIT_EXT_OUT_EN] &
                             (~standby | run_stdby_ff); // RULE3 RULE13

   // ----------------------------------------
   // interrupt request
   // ----------------------------------------
   assign irq              = |(flags_ff & ien_ff); // RULE24

endmodule

// file: design/dac_ctrl_map.vh
`ifndef DAC_CTRL_MAP_VH
`define DAC_CTRL_MAP_VH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define IDX_CONTROL_A        4'h0
`define IDX_CONTROL_B        4'h1
`define IDX_EVENT_CONTROL    4'h2
`define IDX_IRQ_ENABLE_CLEAR 4'h4
`define IDX_IRQ_ENABLE_SET   4'h5
`define IDX_IRQ_FLAGS        4'h6
`define IDX_SYNC_STATUS      4'h7
`define IDX_CONV_VALUE       4'h8
`define IDX_CONV_BUFFER      4'hc

// ----------------------------------------
// control_a fields
// ----------------------------------------
`define BIT_SOFT_RESET       0
`define BIT_ENABLE           1
`define BIT_RUN_IN_STANDBY   2

// ----------------------------------------
// control_b fields
// ----------------------------------------
`define BIT_EXT_OUT_EN       0
`define BIT_INT_OUT_EN       1
`define BIT_LEFT_ALIGN       2
`define BIT_PUMP_DISABLE     3
`define BIT_BUF_PROT_BYPASS  4
`define BIT_REF_SEL_LO       6
`define BIT_REF_SEL_HI       7
`define MASK_CONTROL_B       8'hdf

// ----------------------------------------
// event control, irq and sync status fields
// ----------------------------------------
`define BIT_START_EVENT_IN   0
`define BIT_EMPTY_EVENT_OUT  1
`define BIT_IRQ_UNDERRUN     0
`define BIT_IRQ_EMPTY        1
`define BIT_IRQ_SYNC_READY   2
`define BIT_SYNC_BUSY        7

// ----------------------------------------
// reference select codes
// ----------------------------------------
`define REF_INTERNAL_1V      2'h0
`define REF_ANALOG_SUPPLY    2'h1
`define REF_EXTERNAL         2'h2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_BYTE             8'h00
`define RST_DATA             16'h0000
`define RST_BUF_FULL         1'b1
`define SYNC_CYCLES          4

`endif

// file: design/sync_delay.v
`timescale 1ns/1ns

// ----------------------------------------
// write synchronisation delay
// ----------------------------------------
module sync_delay #(
   parameter CYCLES = 4
) (
   input  wire clk,    // bus clock
   input  wire rst_n,  // async reset, active low
   input  wire start,  // one-cycle start pulse
   output wire busy,   // high while delay runs
   output wire done    // one-cycle pulse at the end
);

   reg  [7:0] cnt_ff;
   reg        busy_ff;
   wire       last;

   assign last = (cnt_ff == 8'h01);
   assign busy = busy_ff;
   assign done = busy_ff & last;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff  <= 8'h00;
         busy_ff <= 1'b0;
      end else if (start && !busy_ff) begin
         cnt_ff  <= CYCLES[7:0];
         busy_ff <= 1'b1;
      end else if (busy_ff) begin
         cnt_ff  <= cnt_ff - 8'h01;
         if (last) begin
            busy_ff <= 1'b0;
         end
      end
   end

endmodule

// file: tb/dac_control_chk.sv
`timescale 1ns/1ns
module dac_control_chk #(
   parameter AW = 12
) (
   input wire          pclk,          // clock
   input wire          presetn,       // reset, active low
   input wire          psel,          // select
   input wire          penable,       // access phase
   input wire          pwrite,        // direction
   input wire [AW-1:0] paddr,         // address
   input wire          pready,        // ready
   input wire          pslverr,       // error
   input wire          write_protect, // protection on
   input wire          start_event,   // start event
   input wire          dac_on,        // converter on
   input wire          conv_start,    // conversion pulse
   input wire          internal_out,  // comparator path
   input wire          external_out,  // pin buffer
   input wire          empty_event    // empty event pulse
);
   // ----------------------------------------
   // bus and output relations
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc   = psel && penable;
   wire wdone = acc && pwrite && pready;

   read_ready_a: assert property (acc && !pwrite |-> pready)
      else $error("read stalled");
   stall_bound_a: assert property (acc && !pready |-> ##[1:12] pready)
      else $error("write stall too long");
   unmapped_err_a: assert property (acc && pready && (paddr[AW-1:6] != 0 || paddr == 12'h00c) |-> pslverr)
      else $error("unmapped access not refused");
   protect_err_a: assert property (wdone && write_protect && paddr == 12'h000 |-> pslverr)
      else $error("protected write accepted");
   int_path_a: assert property (internal_out |-> dac_on)
      else $error("internal path on while disabled");
   ext_path_a: assert property (external_out |-> dac_on)
      else $error("pin buffer on while disabled");
   empty_event_a: assert property (empty_event |-> conv_start)
      else $error("empty event without buffer move");
   conv_cause_a: assert property ($rose(conv_start) |-> $past(start_event) || $past(start_event, 2))
      else $error("conversion without start event");

   cover property (conv_start && empty_event);
   cover property (acc && !pready);
   cover property (wdone && pslverr);
endmodule

// file: tb/tb_dac_control.sv
`timescale 1ns/1ns
`include "dac_ctrl_map.vh"
module tb_dac_control;
   localparam logic [11:0] CA = {6'h00, `IDX_CONTROL_A, 2'b00};
   localparam logic [11:0] CB = {6'h00, `IDX_CONTROL_B, 2'b00};
   localparam logic [11:0] EV = {6'h00, `IDX_EVENT_CONTROL, 2'b00};
   localparam logic [11:0] EC = {6'h00, `IDX_IRQ_ENABLE_CLEAR, 2'b00};
   localparam logic [11:0] ES = {6'h00, `IDX_IRQ_ENABLE_SET, 2'b00};
   localparam logic [11:0] FL = {6'h00, `IDX_IRQ_FLAGS, 2'b00};
   localparam logic [11:0] ST = {6'h00, `IDX_SYNC_STATUS, 2'b00};
   localparam logic [11:0] VA = {6'h00, `IDX_CONV_VALUE, 2'b00};
   localparam logic [11:0] BU = {6'h00, `IDX_CONV_BUFFER, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, write_protect, standby, start_event;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pstrb;
   logic        pready, pslverr, err, dac_on, conv_start, pump_off, internal_out, external_out;
   logic        empty_event, irq, seen_c, seen_e;
   logic [9:0]  dac_code;
   logic [1:0]  reference_select;
   int          n_fail, check_count, cyc, i;
   logic [11:0] regs [9];

   dac_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .write_protect(write_protect), .standby(standby), .start_event(start_event), .dac_on(dac_on),
      .dac_code(dac_code), .conv_start(conv_start), .reference_select(reference_select), .pump_off(pump_off),
      .internal_out(internal_out), .external_out(external_out), .empty_event(empty_event), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ----------------------------------------
   // bus tasks and checks
   // ----------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hf);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, 4'h0);
      chk($sformatf("reg %h", a), e, rdat);
   endtask

   task idle;
      int k;
      k = 0;
      rdat = 32'h80;
      while (rdat[7] && k < 20) begin
         xfer(1'b0, ST, 32'h0, 4'h0);
         k++;
      end
      chk("sync_busy idle", 0, rdat[7]);
   endtask

   task ev;
      @(posedge pclk) start_event <= 1'b1;
      @(posedge pclk) start_event <= 1'b0;
      seen_c = 1'b0;
      seen_e = 1'b0;
      repeat (3) begin
         #1;
         seen_c = seen_c | conv_start;
         seen_e = seen_e | empty_event;
         @(posedge pclk);
      end
   endtask

   task results;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         results();
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, write_protect, standby, start_event} = 7'h00;
      paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; cyc = 0; n_fail = 0; check_count = 0;
      regs = '{CA, CB, EV, EC, ES, FL, ST, VA, BU};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 9; i++) rd(regs[i], 32'h0);
      rd(12'h00c, 32'h0); chk("unmapped err", 1, err);
      wr(CB, 32'hdf); rd(CB, 32'hdf); chk("pump_off", 1, pump_off);
      for (i = 0; i < 3; i++) begin
         wr(CB, 32'(i) << 6); chk("reference_select", i, reference_select);
      end
      wr(CA, 32'h2); rd(ST, 32'h80); rd(CA, 32'h2);
      idle(); chk("dac_on", 1, dac_on); rd(FL, 32'h0);
      wr(CB, 32'h3); chk("internal_out", 1, internal_out); chk("external_out", 1, external_out);
      @(posedge pclk) standby <= 1'b1;
      @(posedge pclk) #1 chk("external_out standby", 0, external_out);
      wr(CA, 32'h6);
      wr(CA, 32'h6); chk("stalled write err", 0, err);
      idle(); chk("external_out run", 1, external_out);
      wr(EV, 32'h3); wr(ES, 32'h7); rd(EC, 32'h7);
      wr(BU, 32'h155); idle(); rd(FL, 32'h4); chk("irq", 1, irq);
      wr(FL, 32'h4); chk("irq clear", 0, irq);
      ev(); chk("conv_start", 1, seen_c); chk("empty_event", 1, seen_e);
      chk("dac_code right", 32'h155, dac_code); rd(FL, 32'h2);
      ev(); rd(FL, 32'h3);
      wr(EC, 32'h1); rd(ES, 32'h6);
      wr(CB, 32'h17); wr(BU, 32'hffc0); idle(); rd(FL, 32'h5);
      ev(); chk("dac_code left", 32'h3ff, dac_code);
      wr(EV, 32'h1); wr(BU, 32'h40); idle(); ev(); chk("empty_event off", 0, seen_e);
      chk("conv_start", 1, seen_c); chk("dac_code left low", 32'h1, dac_code);
      @(posedge pclk) write_protect <= 1'b1;
      wr(CB, 32'h0); chk("protect err", 1, err); rd(CB, 32'h17);
      wr(BU, 32'h1); chk("bypass err", 0, err);
      wr(CA, 32'h0); chk("control_a err", 1, err);
      @(posedge pclk) write_protect <= 1'b0;
      xfer(1'b1, BU, 32'haa00, 4'h2); idle(); rd(BU, 32'haa01);
      wr(CA, 32'h1); rd(CA, 32'h7);
      idle(); rd(CA, 32'h0); rd(CB, 32'h0); chk("dac_on reset", 0, dac_on);
      rd(FL, 32'h0); rd(ST, 32'h0);
      results();
   end
endmodule

bind dac_control dac_control_chk #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .write_protect(write_protect), .start_event(start_event), .dac_on(dac_on), .conv_start(conv_start),
   .internal_out(internal_out), .external_out(external_out), .empty_event(empty_event));
